//--- design/bcr_pkg.sv
// Package of constants and types for the banked core register file
// Summary of operation
// - Sixteen 32-bit registers; last is program counter.
// - Writing program counter redirects instruction fetch.
// - Low registers and counter shared across modes.
// - Registers eight to twelve banked for fast interrupt.
// - Modes other than user and system bank stack pointer and saved status.
// - Bank chosen from mode field, not access.
// - Exception modes other than hypervisor bank link register, get return.
// - Counter reads ahead eight or four bytes.
// - Counter read clears low bits per state.
// - General registers need no reset value.
// - Hypervisor banks stack, saved status, exception return.
// - Hypervisor only usable in non-secure world.
// - Exception entry saves old status word.
// - Saved status inaccessible from user mode.
// - User status access limited to application flags.
// - Status word holds negative, zero, carry, overflow.
// - Saturation flag is sticky until cleared.
// - Status holds greater-equal and if-then fields.
// - Three mask bits disable abort, interrupt, fast.
// - Status holds endian, compact, bytecode state bits.
// - Five-bit mode field selects the bank.
// - User writes cannot change mode or masks.
// - Mode encodings as listed for nine modes.
// - Monitor secure only, hypervisor non-secure only.
package bcr_pkg;

	// ----------------------------------------------------------------
	// Mode encodings
	// ----------------------------------------------------------------
	localparam logic [4:0] MODE_USR = 5'h10; // User
	localparam logic [4:0] MODE_FIQ = 5'h11; // Fast interrupt
	localparam logic [4:0] MODE_IRQ = 5'h12; // Interrupt
	localparam logic [4:0] MODE_SVC = 5'h13; // Supervisor
	localparam logic [4:0] MODE_MON = 5'h16; // Monitor
	localparam logic [4:0] MODE_ABT = 5'h17; // Abort
	localparam logic [4:0] MODE_HYP = 5'h1a; // Hypervisor
	localparam logic [4:0] MODE_UND = 5'h1b; // Undefined
	localparam logic [4:0] MODE_SYS = 5'h1f; // System

	// ----------------------------------------------------------------
	// Status word field positions
	// ----------------------------------------------------------------
	localparam int PSR_N = 31; // Negative
	localparam int PSR_Z = 30; // Zero
	localparam int PSR_C = 29; // Carry
	localparam int PSR_V = 28; // Overflow
	localparam int PSR_Q = 27; // Sticky saturation
	localparam int PSR_J = 24; // Bytecode state
	localparam int PSR_E = 9; // Endianness
	localparam int PSR_A = 8; // Abort mask
	localparam int PSR_I = 7; // Interrupt mask
	localparam int PSR_F = 6; // Fast interrupt mask
	localparam int PSR_T = 5; // Compact state

	// Application view: N Z C V Q and greater_equal_bits [19:16]
	localparam logic [31:0] APP_VIEW_MASK = 32'hf80f0000;
	// Bits user writes may change: flags, greater_equal_bits
	localparam logic [31:0] USER_WR_MASK = 32'hf80f0000;
	// Full layout of defined status bits
	localparam logic [31:0] PSR_DEF_MASK = 32'hff0fffff;

	// ----------------------------------------------------------------
	// Reset values and counter offsets
	// ----------------------------------------------------------------
	localparam logic [31:0] PSR_RESET = 32'h000001d3; // SVC, A I F set
	localparam logic [31:0] PC_RESET = 32'h00000000;
	localparam logic [31:0] PC_AHEAD_WIDE = 32'h00000008;
	localparam logic [31:0] PC_AHEAD_COMPACT = 32'h00000004;
	localparam logic [3:0] REG_SP = 4'hd;
	localparam logic [3:0] REG_LR = 4'he;
	localparam logic [3:0] REG_PC = 4'hf;

	// ----------------------------------------------------------------
	// Bank indices
	// ----------------------------------------------------------------
	localparam int NUM_BANKS = 8;
	localparam logic [2:0] BANK_USR = 3'h0;
	localparam logic [2:0] BANK_FIQ = 3'h1;
	localparam logic [2:0] BANK_IRQ = 3'h2;
	localparam logic [2:0] BANK_SVC = 3'h3;
	localparam logic [2:0] BANK_ABT = 3'h4;
	localparam logic [2:0] BANK_UND = 3'h5;
	localparam logic [2:0] BANK_MON = 3'h6;
	localparam logic [2:0] BANK_HYP = 3'h7;

	// ----------------------------------------------------------------
	// Wishbone addresses (word index)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADR_STATUS = 4'h0;
	localparam logic [3:0] ADR_SAVED = 4'h1;
	localparam logic [3:0] ADR_ELR = 4'h2;
	localparam logic [3:0] ADR_CTRL = 4'h3;
	localparam logic [3:0] ADR_PC = 4'h4;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic we; // Write request
		logic [3:0] idx; // Architectural number
		logic [31:0] data; // Write data
	} bcr_wr_t;

	typedef struct packed {
		logic take; // Exception taken (pulse)
		logic [4:0] mode; // Mode being entered
		logic [31:0] ret; // Return address for link
		logic [31:0] vector; // New fetch address
	} bcr_exc_t;

	typedef struct packed {
		logic upd; // Flag update strobe
		logic [3:0] nzcv; // New condition flags
		logic sat; // Saturation occurred
		logic ge_upd; // Greater-equal update
		logic [3:0] ge; // New greater-equal bits
		logic it_upd; // If-then update
		logic [7:0] it; // New if-then state
	} bcr_flags_t;

	// Wishbone slave state
	typedef enum logic [1:0] {
		WB_IDLE = 2'b01,
		WB_ACK = 2'b10
	} bcr_wb_st_t;

endpackage

//--- design/bcr_bank_sel.sv
// Bank decode from mode field and architectural number
`timescale 1ns/1ps
`default_nettype none
module bcr_bank_sel (
	// Selection inputs
	input wire logic [4:0] mode_i,
	input wire logic [3:0] idx_i,
	// Decoded bank and flags
	output logic [2:0] bank_o,
	output logic banked_o,
	output logic fiq_hi_o,
	output logic mode_ok_o
);
	import bcr_pkg::*;

	// Mode to bank, combinational
	always_comb begin
		mode_ok_o = 1'b1;
		case (mode_i)
			MODE_USR: bank_o = BANK_USR;
			MODE_SYS: bank_o = BANK_USR;
			MODE_FIQ: bank_o = BANK_FIQ;
			MODE_IRQ: bank_o = BANK_IRQ;
			MODE_SVC: bank_o = BANK_SVC;
			MODE_ABT: bank_o = BANK_ABT;
			MODE_UND: bank_o = BANK_UND;
			MODE_MON: bank_o = BANK_MON;
			MODE_HYP: bank_o = BANK_HYP;
			default: begin
				bank_o = BANK_USR;
				mode_ok_o = 1'b0;
			end
		endcase
	end

	// Stack pointer banked everywhere but user bank; link not in hyp
	assign banked_o = (idx_i == REG_SP) ? (bank_o != BANK_USR) :
		(idx_i == REG_LR) ? (bank_o != BANK_USR && bank_o != BANK_HYP) :
		1'b0;
	// Registers eight to twelve in fast interrupt bank
	assign fiq_hi_o = (bank_o == BANK_FIQ) && (idx_i >= 4'h8) && (idx_i <= 4'hc);
endmodule
`default_nettype wire

//--- design/bcr_regfile.sv
// Banked core register file with status words and Wishbone access
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module bcr_regfile (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Security world
	input wire logic nonsecure_i,
	// Read ports
	input wire logic [3:0] rd_a_idx_i,
	input wire logic [3:0] rd_b_idx_i,
	output logic [31:0] rd_a_data_o,
	output logic [31:0] rd_b_data_o,
	// Write port and counter advance
	input wire bcr_pkg::bcr_wr_t wr_i,
	input wire logic pc_step_i,
	// Flag updates from the arithmetic unit
	input wire bcr_pkg::bcr_flags_t flags_i,
	// Exception entry
	input wire bcr_pkg::bcr_exc_t exc_i,
	// Fetch redirect
	output logic [31:0] fetch_addr_o,
	output logic redirect_o,
	// Status outputs
	output logic [31:0] status_o,
	output logic mode_fault_o,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o
);
	import bcr_pkg::*;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// Banked arrays are indexed by bank number; unused slots are never read
	logic [31:0] low_ff [0:7]; // Shared R0..R7
	logic [31:0] hi_ff [0:4]; // Common R8..R12
	logic [31:0] fiq_hi_ff [0:4]; // Fast interrupt R8..R12
	logic [31:0] sp_ff [0:NUM_BANKS-1]; // Banked stack pointers
	logic [31:0] lr_ff [0:NUM_BANKS-1]; // Banked links, hyp slot written on entry but never read
	logic [31:0] saved_status_word_ff [0:NUM_BANKS-1]; // Saved status, user unused
	logic [31:0] pc_ff; // Current instruction address
	logic [31:0] psr_ff; // Current status word
	logic [31:0] elr_ff; // Hypervisor exception return
	logic redirect_ff; // Fetch redirect pulse
	logic [31:0] wb_dat_ff; // Registered bus read data
	bcr_wb_st_t wb_st_ff; // Bus slave state
	logic wb_err_ff; // Bus error
	logic [31:0] nxt_psr; // Next status word

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic [2:0] cur_bank; // Bank of the current mode
	logic wr_banked; // Write index hits banked copy
	logic wr_fiq_hi; // Write index hits fast copy
	logic mode_ok; // Mode field legal
	logic is_user; // Current mode is user
	logic has_saved_status_word; // Current mode owns a saved status
	logic [2:0] exc_bank; // Bank of mode being entered

	// Bank of the current mode, for reads and core writes
	bcr_bank_sel u_wr_sel (
		.mode_i(psr_ff[4:0]),
		.idx_i(wr_i.idx),
		.bank_o(cur_bank),
		.banked_o(wr_banked),
		.fiq_hi_o(wr_fiq_hi),
		.mode_ok_o(mode_ok)
	);

	// Mode class of the current status word
	assign is_user = (psr_ff[4:0] == MODE_USR);
	assign has_saved_status_word = (cur_bank != BANK_USR);
	// Hypervisor out of secure world, monitor out of normal world
	assign mode_fault_o = !mode_ok ||
		(psr_ff[4:0] == MODE_HYP && !nonsecure_i) ||
		(psr_ff[4:0] == MODE_MON && nonsecure_i);
	// Registered state straight to the ports
	assign status_o = psr_ff;
	assign fetch_addr_o = pc_ff;
	assign redirect_o = redirect_ff;

	// Read value of counter: ahead and low bits cleared
	function automatic logic [31:0] pc_view(input logic [31:0] pc, input logic t);
		logic [31:0] v;
		v = pc + (t ? PC_AHEAD_COMPACT : PC_AHEAD_WIDE);
		pc_view = t ? {v[31:1], 1'b0} : {v[31:2], 2'b00};
	endfunction

	// Architectural read through the current bank
	function automatic logic [31:0] arch_read(input logic [3:0] idx);
		logic [31:0] v;
		v = 32'h00000000;
		if (idx < 4'h8) begin
			v = low_ff[idx[2:0]];
		end else if (idx <= 4'hc) begin
			v = (cur_bank == BANK_FIQ) ? fiq_hi_ff[3'(idx - 4'h8)] :
				hi_ff[3'(idx - 4'h8)];
		end else if (idx == REG_SP) begin
			v = sp_ff[cur_bank];
		end else if (idx == REG_LR) begin
			v = (cur_bank == BANK_HYP) ? lr_ff[BANK_USR] : lr_ff[cur_bank];
		end else begin
			// Counter reads ahead of the fetch address
			v = pc_view(pc_ff, psr_ff[PSR_T]);
		end
		arch_read = v;
	endfunction

	// Read ports, registered data
	always_ff @(posedge clk_i) begin
		rd_a_data_o <= arch_read(rd_a_idx_i);
		rd_b_data_o <= arch_read(rd_b_idx_i);
	end

	// ----------------------------------------------------------------
	// General registers (no reset needed)
	// ----------------------------------------------------------------
	logic wr_gp; // Core write below counter
	assign wr_gp = wr_i.we && (wr_i.idx != REG_PC);

	// Shared and high registers
	always_ff @(posedge clk_i) begin
		if (wr_gp && wr_i.idx < 4'h8) begin
			low_ff[wr_i.idx[2:0]] <= wr_i.data;
		end
		if (wr_gp && wr_i.idx >= 4'h8 && wr_i.idx <= 4'hc) begin
			if (wr_fiq_hi) begin
				fiq_hi_ff[3'(wr_i.idx - 4'h8)] <= wr_i.data;
			end else begin
				hi_ff[3'(wr_i.idx - 4'h8)] <= wr_i.data;
			end
		end
	end

	// Stack pointers and links; exception writes link in same cycle
	always_ff @(posedge clk_i) begin
		if (exc_i.take) begin
			lr_ff[exc_bank] <= exc_i.ret;
		end else if (wr_gp && wr_i.idx == REG_LR) begin
			// Hypervisor and user bank share the user link
			lr_ff[wr_banked ? cur_bank : BANK_USR] <= wr_i.data;
		end
		if (!exc_i.take && wr_gp && wr_i.idx == REG_SP) begin
			sp_ff[wr_banked ? cur_bank : BANK_USR] <= wr_i.data;
		end
	end

	// ----------------------------------------------------------------
	// Exception bank
	// ----------------------------------------------------------------
	// Second decoder for the mode being entered, not the current one
	bcr_bank_sel u_exc_sel (
		.mode_i(exc_i.mode),
		.idx_i(REG_LR),
		.bank_o(exc_bank),
		.banked_o(),
		.fiq_hi_o(),
		.mode_ok_o()
	);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic wb_req; // New request
	logic wb_wr; // Write accepted this cycle
	logic [3:0] wb_idx; // Word index
	logic wb_map; // Address mapped and permitted
	logic [31:0] wb_mask; // Byte lane mask
	// A request is taken only while the slave is idle
	assign wb_req = wb_cyc_i && wb_stb_i && (wb_st_ff == WB_IDLE);
	assign wb_idx = wb_adr_i[5:2];
	assign wb_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wb_map = (wb_idx == ADR_STATUS) || (wb_idx == ADR_CTRL) || (wb_idx == ADR_PC) ||
		(wb_idx == ADR_SAVED && !is_user && has_saved_status_word) ||
		(wb_idx == ADR_ELR && cur_bank == BANK_HYP && nonsecure_i);
	// A refused write leaves every register alone
	assign wb_wr = wb_req && wb_we_i && wb_map;

	// Status write data through user restriction
	function automatic logic [31:0] psr_merge(input logic [31:0] old, input logic [31:0] d,
		input logic [31:0] lanes, input logic user);
		logic [31:0] m;
		m = lanes & PSR_DEF_MASK;
		if (user) begin
			m = m & USER_WR_MASK;
		end
		psr_merge = (old & ~m) | (d & m);
	endfunction

	// ----------------------------------------------------------------
	// Status word
	// ----------------------------------------------------------------
	// Order: bus write, then core flags, then exception entry
	always_comb begin
		nxt_psr = psr_ff;
		if (wb_wr && wb_idx == ADR_STATUS) begin
			nxt_psr = psr_merge(psr_ff, wb_dat_i, wb_mask, is_user);
		end
		if (flags_i.upd) begin
			nxt_psr[31:28] = flags_i.nzcv;
		end
		// Set after the bus merge so a same-cycle clear loses
		if (flags_i.sat) begin
			nxt_psr[PSR_Q] = 1'b1;
		end
		if (flags_i.ge_upd) begin
			nxt_psr[19:16] = flags_i.ge;
		end
		if (flags_i.it_upd) begin
			nxt_psr[15:10] = flags_i.it[7:2];
			nxt_psr[26:25] = flags_i.it[1:0];
		end
		// Exception entry overrides mode, I mask (F too for fast interrupt) and clears T and J last
		if (exc_i.take) begin
			nxt_psr[4:0] = exc_i.mode;
			nxt_psr[PSR_I] = 1'b1;
			nxt_psr[PSR_T] = 1'b0;
			nxt_psr[PSR_J] = 1'b0;
			if (exc_i.mode == MODE_FIQ) begin
				nxt_psr[PSR_F] = 1'b1;
			end
		end
	end

	// Current status register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			psr_ff <= PSR_RESET;
		end else begin
			psr_ff <= nxt_psr;
		end
	end

	// Saved status: copy of old word on exception, or bus write
	always_ff @(posedge clk_i) begin
		if (exc_i.take) begin
			saved_status_word_ff[exc_bank] <= psr_ff;
		end else if (wb_wr && wb_idx == ADR_SAVED) begin
			saved_status_word_ff[cur_bank] <= (saved_status_word_ff[cur_bank] & ~wb_mask) | (wb_dat_i & wb_mask);
		end
	end

	// Hypervisor exception return
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			elr_ff <= PC_RESET;
		end else if (exc_i.take && exc_i.mode == MODE_HYP) begin
			elr_ff <= exc_i.ret;
		end else if (wb_wr && wb_idx == ADR_ELR) begin
			elr_ff <= (elr_ff & ~wb_mask) | (wb_dat_i & wb_mask);
		end
	end

	// ----------------------------------------------------------------
	// Program counter
	// ----------------------------------------------------------------
	logic pc_wr; // Any counter write
	assign pc_wr = (wr_i.we && wr_i.idx == REG_PC) || (wb_wr && wb_idx == ADR_PC);

	// Counter: exception vector first, then writes, then advance
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_ff <= PC_RESET;
		end else if (exc_i.take) begin
			pc_ff <= exc_i.vector;
		end else if (wr_i.we && wr_i.idx == REG_PC) begin
			pc_ff <= wr_i.data;
		end else if (wb_wr && wb_idx == ADR_PC) begin
			pc_ff <= (pc_ff & ~wb_mask) | (wb_dat_i & wb_mask);
		end else if (pc_step_i) begin
			// Two bytes per step in the compact state, four otherwise
			pc_ff <= pc_ff + (psr_ff[PSR_T] ? 32'h00000002 : 32'h00000004);
		end
	end

	// Fetch redirect pulse after any change of flow
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			redirect_ff <= 1'b0;
		end else begin
			redirect_ff <= exc_i.take || pc_wr;
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	// Read mux of the bus view
	function automatic logic [31:0] bus_read(input logic [3:0] a);
		logic [31:0] v;
		v = 32'h00000000;
		case (a)
			ADR_STATUS: v = is_user ? (psr_ff & APP_VIEW_MASK) : psr_ff;
			ADR_SAVED: v = saved_status_word_ff[cur_bank];
			ADR_ELR: v = elr_ff;
			ADR_CTRL: v = {24'h000000, 1'b0, cur_bank, 2'b00, nonsecure_i, mode_fault_o};
			ADR_PC: v = pc_view(pc_ff, psr_ff[PSR_T]);
			default: v = 32'h00000000;
		endcase
		bus_read = v;
	endfunction

	// One registered ack or err per request, the cycle after it is taken, then one idle cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_st_ff <= WB_IDLE;
			wb_dat_ff <= 32'h00000000;
			wb_err_ff <= 1'b0;
		end else begin
			case (wb_st_ff)
				WB_IDLE: begin
					if (wb_req) begin
						wb_st_ff <= WB_ACK;
						// Refused requests answer with err and read as zero
						wb_dat_ff <= wb_map ? bus_read(wb_idx) : 32'h00000000;
						wb_err_ff <= !wb_map;
					end
				end
				WB_ACK: begin
					wb_st_ff <= WB_IDLE;
					wb_err_ff <= 1'b0;
				end
				default: wb_st_ff <= WB_IDLE;
			endcase
		end
	end

	// Answer strobes decoded from the state register
	assign wb_ack_o = (wb_st_ff == WB_ACK) && !wb_err_ff;
	assign wb_err_o = (wb_st_ff == WB_ACK) && wb_err_ff;
	assign wb_dat_o = wb_dat_ff;
endmodule
`default_nettype wire

//--- dv/bcr_regfile_asserts.sv
// Checker of the banked register file port behaviour
`timescale 1ns/1ps
`default_nettype none
module bcr_regfile_asserts (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Watched inputs
	input wire logic nonsecure_i,
	input wire logic pc_step_i,
	input wire bcr_pkg::bcr_wr_t wr_i,
	input wire bcr_pkg::bcr_exc_t exc_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	// Watched outputs
	input wire logic [31:0] fetch_addr_o,
	input wire logic redirect_o,
	input wire logic [31:0] status_o,
	input wire logic mode_fault_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o
);
	import bcr_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic bus_w; // Request seen by an idle slave
	logic user_w; // Running in user mode
	logic pcw_w; // Core write to the counter
	assign bus_w = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign user_w = status_o[4:0] == MODE_USR;
	assign pcw_w = wr_i.we && wr_i.idx == REG_PC;
	// Entry steps seen one cycle after the pulse
	sequence s_entered;
		redirect_o && status_o[PSR_I] && status_o[4:0] == $past(exc_i.mode);
	endsequence
	sequence s_vectored;
		fetch_addr_o == $past(exc_i.vector);
	endsequence
	AST_RESET_STATE: assert property (
		$fell(rst_i) |-> status_o == PSR_RESET && fetch_addr_o == PC_RESET)
		else $error("status or counter wrong after reset");
	AST_EXC_ENTRY: assert property (
		exc_i.take |=> s_entered ##0 s_vectored)
		else $error("exception entry incomplete");
	AST_PC_WRITE: assert property (
		pcw_w && !exc_i.take |=> redirect_o && fetch_addr_o == $past(wr_i.data))
		else $error("counter write did not redirect");
	AST_PC_STEP: assert property (
		pc_step_i && !pcw_w && !exc_i.take && !(bus_w && wb_we_i)
		|=> fetch_addr_o == $past(fetch_addr_o) + ($past(status_o[PSR_T]) ? 32'h2 : 32'h4))
		else $error("counter advance wrong");
	AST_Q_STICKY: assert property (
		status_o[PSR_Q] && !(bus_w && wb_we_i) |=> status_o[PSR_Q])
		else $error("saturation flag lost");
	AST_USER_LOCK: assert property (
		user_w && !exc_i.take |=> user_w && $stable(status_o[8:6]))
		else $error("user changed mode or masks");
	AST_SAVED_USER: assert property (
		bus_w && user_w && wb_adr_i == 6'h04 |=> wb_err_o && !wb_ack_o)
		else $error("saved status reachable in user mode");
	AST_HYP_SECURE: assert property (
		bus_w && wb_adr_i == 6'h08 && !nonsecure_i |=> wb_err_o && !wb_ack_o)
		else $error("hypervisor return reachable while secure");
	AST_WORLD_FAULT: assert property (
		(nonsecure_i && status_o[4:0] == MODE_MON) || (!nonsecure_i && status_o[4:0] == MODE_HYP)
		|-> mode_fault_o)
		else $error("mode not flagged for this world");
endmodule
bind bcr_regfile bcr_regfile_asserts i_chk (.clk_i, .rst_i, .nonsecure_i, .pc_step_i, .wr_i,
	.exc_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .fetch_addr_o, .redirect_o, .status_o,
	.mode_fault_o, .wb_ack_o, .wb_err_o);
`default_nettype wire

//--- dv/bcr_regfile_tb_top.sv
// Self-checking testbench of the banked register file
`timescale 1ns/1ps
`default_nettype none
module bcr_regfile_tb_top;
	import bcr_pkg::*;
	// --------------------------------
	// Signals and model state
	// --------------------------------
	logic clk_i, rst_i, nonsecure_i, pc_step_i, redirect_o, mode_fault_o;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, e;
	logic [3:0] rd_a_idx_i, rd_b_idx_i, wb_sel_i;
	logic [5:0] wb_adr_i;
	logic [31:0] rd_a_data_o, rd_b_data_o, fetch_addr_o, status_o, wb_dat_i, wb_dat_o;
	bcr_wr_t wr_i;
	bcr_flags_t flags_i;
	bcr_exc_t exc_i;
	int errors, samples_checked;
	logic [31:0] st, pc, d, x; // Model status, counter, bus data, scratch
	logic [31:0] rf[int]; // Model registers keyed by bank and number
	logic [4:0] ml[8] = '{MODE_SYS, MODE_FIQ, MODE_IRQ, MODE_SVC,
		MODE_ABT, MODE_UND, MODE_MON, MODE_HYP};
	bcr_regfile i_dut (.*);
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// --------------------------------
	// Model and drivers
	// --------------------------------
	function automatic int bk(input logic [4:0] m);
		case (m)
			MODE_FIQ: return 1;
			MODE_IRQ: return 2;
			MODE_SVC: return 3;
			MODE_ABT: return 4;
			MODE_UND: return 5;
			MODE_MON: return 6;
			MODE_HYP: return 7;
			default: return 0;
		endcase
	endfunction
	// Physical slot reached by a number in the current mode
	function automatic int rk(input logic [3:0] i);
		int b;
		b = bk(st[4:0]);
		if (i == 4'hd || (i == 4'he && b != 7)) return b * 16 + i;
		if (i >= 4'h8 && i <= 4'hc && b == 1) return 16 + i;
		return i;
	endfunction
	task automatic chk(input string n, input logic [31:0] xp, input logic [31:0] got);
		samples_checked++;
		if (got !== xp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, xp, got);
		end
	endtask
	// One classic cycle; request held until the edge that samples ack or err
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= v;
		do begin
			@(posedge clk_i);
			n++;
		end while (!(wb_ack_o || wb_err_o) && n < 20);
		e = wb_err_o;
		d = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (!(wb_ack_o || wb_err_o)) errors++;
	endtask
	task automatic sts();
		@(negedge clk_i);
		chk("status", st, status_o);
	endtask
	task automatic seen();
		@(negedge clk_i);
		chk("redirect", 32'h1, 32'(redirect_o));
		chk("fetch", pc, fetch_addr_o);
	endtask
	task automatic core_wr(input logic [3:0] i, input logic [31:0] v);
		@(posedge clk_i);
		wr_i <= {1'b1, i, v};
		@(posedge clk_i);
		wr_i.we <= 1'b0;
		if (i == REG_PC) pc = v;
		else rf[rk(i)] = v;
	endtask
	task automatic rd(input logic [3:0] i, input logic [3:0] j);
		@(posedge clk_i);
		rd_a_idx_i <= i;
		rd_b_idx_i <= j;
		@(posedge clk_i);
		@(negedge clk_i);
		chk("rd_a", rf[rk(i)], rd_a_data_o);
		chk("rd_b", rf[rk(j)], rd_b_data_o);
	endtask
	// Privileged mode change with random flags, then read back
	task automatic mode(input logic [4:0] m, input logic ns);
		@(posedge clk_i);
		nonsecure_i <= ns || st[4:0] == MODE_HYP;
		x = 32'h1c0 | 32'(m) | ($urandom & 32'hf00f0000);
		bus(1'b1, 6'h00, x);
		nonsecure_i <= ns;
		st = x;
		bus(1'b0, 6'h00, 32'h0);
		chk("status_rd", m == MODE_USR ? st & APP_VIEW_MASK : st, d);
	endtask
	task automatic step(input int n);
		@(posedge clk_i);
		pc_step_i <= 1'b1;
		repeat (n) @(posedge clk_i);
		pc_step_i <= 1'b0;
		pc = pc + n * (st[PSR_T] ? 2 : 4);
		@(negedge clk_i);
		chk("step", pc, fetch_addr_o);
	endtask
	task automatic flg(input logic s);
		bcr_flags_t f;
		f = {1'b1, 4'($urandom), s, 1'b1, 4'($urandom), 1'b1, 8'($urandom)};
		@(posedge clk_i);
		flags_i <= f;
		@(posedge clk_i);
		flags_i <= '0;
		st[31:28] = f.nzcv;
		st[PSR_Q] = st[PSR_Q] | s;
		st[19:16] = f.ge;
		st[26:25] = f.it[1:0];
		st[15:10] = f.it[7:2];
		sts();
	endtask
	task automatic exc(input logic [4:0] m);
		logic [31:0] r;
		r = $urandom & 32'hfffffffc;
		pc = $urandom & 32'hfffffffc;
		@(posedge clk_i);
		exc_i <= {1'b1, m, r, pc};
		@(posedge clk_i);
		exc_i.take <= 1'b0;
		x = st;
		st[4:0] = m;
		st[PSR_I] = 1'b1;
		st[PSR_T] = 1'b0;
		st[PSR_J] = 1'b0;
		if (m == MODE_FIQ) st[PSR_F] = 1'b1;
		seen();
		sts();
		bus(1'b0, 6'h04, 32'h0);
		chk("saved", x, d);
		if (m == MODE_HYP) begin
			bus(1'b0, 6'h08, 32'h0);
			chk("elr", r, d);
		end else begin
			rf[bk(m) * 16 + 14] = r;
			rd(4'he, 4'hd);
		end
	endtask
	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// --------------------------------
	// Tests
	// --------------------------------
	initial begin
		#300000;
		errors++;
		close_out();
	end
	initial begin
		{rd_a_idx_i, rd_b_idx_i, wb_adr_i, wb_dat_i, wr_i, flags_i, exc_i} = '0;
		{nonsecure_i, pc_step_i, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
		rst_i = 1'b1;
		wb_sel_i = 4'hf;
		errors = 0;
		samples_checked = 0;
		void'($urandom(32'h7adf7c29));
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		st = PSR_RESET;
		pc = PC_RESET;
		sts();
		$display("test reset done");
		foreach (ml[k]) begin
			mode(ml[k], ml[k] == MODE_HYP);
			for (int i = 0; i < 15; i++) core_wr(4'(i), $urandom);
		end
		foreach (ml[k]) begin
			mode(ml[k], ml[k] == MODE_HYP);
			rd(4'h0, 4'h7);
			rd(4'h8, 4'hc);
			rd(4'hd, 4'he);
		end
		$display("test banks done");
		mode(MODE_USR, 1'b0);
		rd(4'hd, 4'he);
		bus(1'b0, 6'h04, 32'h0);
		chk("saved_err", 32'h1, 32'(e));
		bus(1'b1, 6'h00, 32'hffffffff);
		st = st | USER_WR_MASK;
		sts();
		flg(1'b0);
		bus(1'b1, 6'h00, 32'h0);
		st = st & ~USER_WR_MASK;
		flg(1'b1);
		flg(1'b0);
		exc(MODE_UND);
		for (int k = 1; k < 8; k++) begin
			mode(MODE_SYS, ml[k] == MODE_HYP);
			exc(ml[k]);
		end
		$display("test user and exceptions done");
		mode(MODE_SVC, 1'b0);
		core_wr(4'hf, $urandom & 32'hfffffffc);
		seen();
		step(3);
		st = 32'h1e0 | 32'(MODE_SVC);
		bus(1'b1, 6'h00, st);
		step(1);
		bus(1'b0, 6'h10, 32'h0);
		chk("pc_compact", (pc + 32'h4) & ~32'h1, d);
		st = 32'h1c0 | 32'(MODE_SVC);
		bus(1'b1, 6'h00, st);
		bus(1'b0, 6'h10, 32'h0);
		chk("pc_wide", (pc + 32'h8) & ~32'h3, d);
		pc = $urandom & 32'hfffffffc;
		bus(1'b1, 6'h10, pc);
		@(negedge clk_i);
		chk("fetch", pc, fetch_addr_o);
		$display("test counter done");
		bus(1'b0, 6'h0c, 32'h0);
		chk("ctrl", 32'h30, d);
		bus(1'b0, 6'h08, 32'h0);
		chk("elr_err", 32'h1, 32'(e));
		bus(1'b0, 6'h14, 32'h0);
		chk("unmapped_err", 32'h1, 32'(e));
		mode(MODE_MON, 1'b0);
		@(posedge clk_i);
		nonsecure_i <= 1'b1;
		@(negedge clk_i);
		chk("fault_mon", 32'h1, 32'(mode_fault_o));
		mode(MODE_HYP, 1'b1);
		@(posedge clk_i);
		nonsecure_i <= 1'b0;
		@(negedge clk_i);
		chk("fault_hyp", 32'h1, 32'(mode_fault_o));
		$display("test worlds done");
		close_out();
	end
endmodule
`default_nettype wire
